// file: hw/bms_block_move.sv
// block-move sequencer: copies bytes from source to destination under a count
// What this block does
// RULE1 - byte form: zero low count byte means no transfer, go to next instruction
// RULE2 - byte form: copy byte, bump both pointers, decrement 8-bit count until zero
// RULE3 - word form: zero 16-bit count means no transfer, go to next instruction
// RULE4 - word form: copy byte, bump both pointers, decrement 16-bit count until zero
// RULE5 - instruction takes eight states plus four states per byte moved
// RULE6 - condition-code flags untouched; no interrupt between byte transfers
module bms_block_move (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// instruction start and operands
	input wire logic start,
	input wire bms_pkg::bms_operands_t operands,
	// memory bus
	output bms_pkg::bms_bus_req_t bus_req,
	input wire logic [bms_pkg::DATA_W-1:0] bus_rdata,
	// results back to the register file
	output logic busy,
	output logic done,
	output logic irq_block,
	output logic [bms_pkg::CNT_W-1:0] count_word,
	output logic [bms_pkg::ADDR_W-1:0] source_pointer,
	output logic [bms_pkg::ADDR_W-1:0] dest_pointer
);
	logic rst_meta_reg;
	logic rst_sync_reg;
	bms_pkg::bms_regs_t s_reg;
	bms_pkg::bms_regs_t s_next;
	logic [bms_pkg::CNT_W-1:0] eff_count;

	// reset release synchroniser
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// byte form looks only at the low byte
	always_comb
	begin
		if (operands.word_form)
			eff_count = operands.count; // RULE3
		else
			eff_count = {{(bms_pkg::CNT_W-bms_pkg::BYTE_CNT_W){1'b0}},
				operands.count[bms_pkg::BYTE_CNT_W-1:0]}; // RULE1
	end

	// count test in the width of the form in use
	function automatic logic count_equals(
		input logic word_form,
		input logic [bms_pkg::CNT_W-1:0] count,
		input logic [bms_pkg::CNT_W-1:0] value
	);
		logic hit;
		if (word_form)
			hit = (count == value); // RULE3 RULE4
		else
			hit = (count[bms_pkg::BYTE_CNT_W-1:0] == value[bms_pkg::BYTE_CNT_W-1:0]); // RULE1 RULE2
		return hit;
	endfunction : count_equals

	// pointer advance after each byte
	function automatic logic [bms_pkg::ADDR_W-1:0] ptr_advance(
		input logic [bms_pkg::ADDR_W-1:0] ptr
	);
		return ptr + bms_pkg::PTR_STEP;
	endfunction : ptr_advance

	// count step after each byte
	function automatic logic [bms_pkg::CNT_W-1:0] count_step(
		input logic [bms_pkg::CNT_W-1:0] count
	);
		return count - bms_pkg::CNT_ONE;
	endfunction : count_step

	// strobes and done last one cycle unless raised again
	function automatic bms_pkg::bms_regs_t clear_pulses(
		input bms_pkg::bms_regs_t cur
	);
		bms_pkg::bms_regs_t nxt;
		nxt = cur;
		nxt.done = 1'b0;
		nxt.bus.rd = 1'b0;
		nxt.bus.wr = 1'b0;
		return nxt;
	endfunction : clear_pulses

	// idle: take the operands on start
	function automatic bms_pkg::bms_regs_t idle_step(
		input bms_pkg::bms_regs_t cur,
		input logic go,
		input bms_pkg::bms_operands_t ops,
		input logic [bms_pkg::CNT_W-1:0] count
	);
		bms_pkg::bms_regs_t nxt;
		nxt = cur;
		if (go)
		begin
			nxt.state = bms_pkg::BMS_SETUP;
			nxt.word_form = ops.word_form;
			nxt.count = count;
			nxt.src = ops.src;
			nxt.dst = ops.dst;
			nxt.setup_cnt = '0;
		end
		return nxt;
	endfunction : idle_step

	// setup: fixed overhead, then finish or issue the first read
	function automatic bms_pkg::bms_regs_t setup_step(
		input bms_pkg::bms_regs_t cur
	);
		bms_pkg::bms_regs_t nxt;
		nxt = cur;
		nxt.setup_cnt = cur.setup_cnt + 4'h1;
		if (cur.setup_cnt == bms_pkg::SETUP_LAST) // RULE5
		begin
			if (count_equals(cur.word_form, cur.count, bms_pkg::CNT_ZERO)) // RULE1 RULE3
			begin
				nxt.state = bms_pkg::BMS_IDLE;
				nxt.done = 1'b1;
			end
			else
			begin
				nxt.state = bms_pkg::BMS_MOVE;
				nxt.phase = bms_pkg::PH_READ;
				nxt.bus.rd = 1'b1;
				nxt.bus.addr = cur.src;
			end
		end
		return nxt;
	endfunction : setup_step

	// move: read, hold, write, advance; four states per byte
	function automatic bms_pkg::bms_regs_t move_step(
		input bms_pkg::bms_regs_t cur,
		input logic [bms_pkg::DATA_W-1:0] rdata
	);
		bms_pkg::bms_regs_t nxt;
		logic [1:0] phase_inc;
		nxt = cur;
		phase_inc = cur.phase + 2'h1;
		nxt.phase = phase_inc;
		// read data stands while rd is high
		if (cur.phase == bms_pkg::PH_READ)
		begin
			nxt.data = rdata; // RULE2 RULE4
		end
		if (phase_inc == bms_pkg::PH_WRITE)
		begin
			nxt.bus.wr = 1'b1;
			nxt.bus.addr = cur.dst;
			nxt.bus.wdata = cur.data; // RULE2 RULE4
		end
		if (cur.phase == bms_pkg::BYTE_LAST) // RULE5
		begin
			nxt.src = ptr_advance(cur.src); // RULE2 RULE4
			nxt.dst = ptr_advance(cur.dst); // RULE2 RULE4
			nxt.count = count_step(cur.count); // RULE2 RULE4
			nxt.phase = bms_pkg::PH_READ;
			if (count_equals(cur.word_form, cur.count, bms_pkg::CNT_ONE)) // RULE2 RULE4
			begin
				nxt.state = bms_pkg::BMS_IDLE;
				nxt.done = 1'b1;
			end
			else
			begin
				nxt.bus.rd = 1'b1;
				nxt.bus.addr = ptr_advance(cur.src);
			end
		end
		return nxt;
	endfunction : move_step

	// one step of the sequencer per clock
	always_comb
	begin
		s_next = clear_pulses(s_reg);
		case (s_reg.state)
			bms_pkg::BMS_IDLE:
			begin
				s_next = idle_step(s_next, start, operands, eff_count);
			end
			bms_pkg::BMS_SETUP:
			begin
				s_next = setup_step(s_next);
			end
			bms_pkg::BMS_MOVE:
			begin
				s_next = move_step(s_next, bus_rdata);
			end
			default:
			begin
				s_next.state = bms_pkg::BMS_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge ref_clk or negedge rst_sync_reg)
	begin
		if (!rst_sync_reg)
			s_reg <= '{state: bms_pkg::BMS_IDLE, default: '0};
		else
			s_reg <= s_next;
	end

	// outputs straight from the state register
	assign bus_req = s_reg.bus;
	assign busy = (s_reg.state != bms_pkg::BMS_IDLE);
	assign irq_block = busy; // RULE6
	assign done = s_reg.done;
	assign source_pointer = s_reg.src;
	assign dest_pointer = s_reg.dst;
	// byte form returns zero in the high count byte
	assign count_word = s_reg.count;
endmodule : bms_block_move

// file: hw/bms_pkg.sv
// package for the block-move sequencer: widths, timing, state and carrier types
package bms_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	localparam int BYTE_CNT_W = 8;
	// fixed overhead and per-byte cost in states
	localparam int SETUP_STATES = 8;
	localparam int BYTE_STATES = 4;
	localparam logic [3:0] SETUP_LAST = 4'(SETUP_STATES - 1);
	localparam logic [1:0] BYTE_LAST = 2'(BYTE_STATES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [ADDR_W-1:0] PTR_STEP = 16'h0001;
	// phases inside one byte iteration
	localparam logic [1:0] PH_READ = 2'h0;
	localparam logic [1:0] PH_WRITE = 2'h2;

	typedef enum logic [1:0] {
		BMS_IDLE,
		BMS_SETUP,
		BMS_MOVE
	} bms_state_t;

	// operands handed over by the cpu at instruction start
	typedef struct packed {
		logic word_form;
		logic [CNT_W-1:0] count;
		logic [ADDR_W-1:0] src;
		logic [ADDR_W-1:0] dst;
	} bms_operands_t;

	// cpu internal bus request
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bms_bus_req_t;

	typedef struct packed {
		bms_state_t state;
		logic word_form;
		logic [3:0] setup_cnt;
		logic [1:0] phase;
		logic [CNT_W-1:0] count;
		logic [ADDR_W-1:0] src;
		logic [ADDR_W-1:0] dst;
		logic [DATA_W-1:0] data;
		bms_bus_req_t bus;
		logic done;
	} bms_regs_t;
endpackage : bms_pkg

// file: tb/bms_mem.sv
// memory partner: read data stands while rd is high, writes recorded
module bms_mem (
	input wire logic ref_clk,
	input wire bms_pkg::bms_bus_req_t bus_req,
	output logic [7:0] bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wmem [256];
	// deselected bus shows the inverse of the addressed byte
	always_comb
	begin
		if (bus_req.rd)
			bus_rdata = bus_req.addr[7:0] ^ 8'h5a;
		else
			bus_rdata = ~(bus_req.addr[7:0] ^ 8'h5a);
	end
	always @(posedge ref_clk)
	begin
		if (bus_req.wr)
			wmem[bus_req.addr[7:0]] <= bus_req.wdata;
	end
endmodule : bms_mem

// file: tb/bms_properties.sv
// checker for the block-move sequencer
module bms_props (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rstn,
	// instruction start and operands
	input wire logic start,
	input wire bms_pkg::bms_operands_t operands,
	// memory bus
	input wire bms_pkg::bms_bus_req_t bus_req,
	input wire logic [bms_pkg::DATA_W-1:0] bus_rdata,
	// status
	input wire logic busy,
	input wire logic done,
	input wire logic irq_block
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	wire go = start && !busy;
	chk_byte_zero: assert property (go && !operands.word_form && operands.count[7:0] == 8'h00
		|-> ##1 !bus_req.rd [*8] ##1 done) else $error("byte form zero count moved data");
	chk_word_zero: assert property (go && operands.word_form && operands.count == 16'h0000
		|-> ##1 !bus_req.rd [*8] ##1 done) else $error("word form zero count moved data");
	chk_copy_byte: assert property (bus_req.rd |-> ##2 bus_req.wr && bus_req.wdata == $past(bus_rdata, 2))
		else $error("byte not copied");
	chk_first_read: assert property (go && operands.word_form && operands.count != 16'h0000
		|-> ##9 bus_req.rd && bus_req.addr == $past(operands.src, 9)) else $error("first read late");
	chk_irq_busy: assert property ((bus_req.rd || bus_req.wr) |-> irq_block) else $error("interrupt hold wrong");
	chk_done_end: assert property (done |-> !busy && $past(busy)) else $error("done outside run");
	cover property (go && operands.word_form);
	cover property (bus_req.wr);
	cover property (done);
endmodule : bms_props
bind bms_block_move bms_props u_props (
	.ref_clk(ref_clk),
	.rstn(rstn),
	.start(start),
	.operands(operands),
	.bus_req(bus_req),
	.bus_rdata(bus_rdata),
	.busy(busy),
	.done(done),
	.irq_block(irq_block)
);

// file: tb/tb.sv
// testbench: zero counts and copies in both forms
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, rstn = 0, start = 0, busy, done, irq_block;
	bms_pkg::bms_operands_t ops = '0;
	bms_pkg::bms_bus_req_t bus_req;
	logic [7:0] bus_rdata;
	logic [15:0] cnt, sp, dp;
	int failures = 0, check_count = 0, cyc = 0;
	bms_block_move dut (.ref_clk(ref_clk), .rstn(rstn), .start(start), .operands(ops), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .busy(busy), .done(done), .irq_block(irq_block), .count_word(cnt), .source_pointer(sp),
		.dest_pointer(dp));
	bms_mem mem (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
	initial forever #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			failures++;
			conclude();
		end
	end
	task automatic chk(input logic [15:0] got, exp);
		check_count++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_done(output int k);
		k = 1;
		@(negedge ref_clk);
		chk({14'h0000, busy, irq_block}, 16'h0003);
		while (done !== 1'b1 && k < 1500)
		begin
			@(negedge ref_clk);
			k++;
		end
		chk({14'h0000, busy, irq_block}, 16'h0000);
	endtask : wait_done
	task automatic check_copy(input logic [15:0] s, d, input int n);
		for (int i = 0; i < n; i++)
			chk({8'h00, mem.wmem[8'(d + 16'(i))]}, {8'h00, 8'(s + 16'(i)) ^ 8'h5a});
	endtask : check_copy
	task automatic run(input logic wf, input logic [15:0] c, s, d, input int n);
		int k;
		@(posedge ref_clk);
		start <= 1'b1;
		ops <= '{wf, c, s, d};
		@(posedge ref_clk);
		start <= 1'b0;
		wait_done(k);
		chk(16'(k), 16'(9 + 4 * n));
		chk(cnt, 16'h0000);
		chk(sp, s + 16'(n));
		chk(dp, d + 16'(n));
		check_copy(s, d, n);
		$display("test end n=%0d", n);
	endtask : run
	task automatic run_refused();
		int k;
		@(posedge ref_clk);
		start <= 1'b1;
		ops <= '{1'b0, 16'h0002, 16'h0050, 16'h0060};
		@(posedge ref_clk);
		start <= 1'b0;
		repeat (3) @(posedge ref_clk);
		start <= 1'b1;
		ops <= '{1'b1, 16'h0005, 16'h0070, 16'h0090};
		@(posedge ref_clk);
		start <= 1'b0;
		wait_done(k);
		chk(16'(k), 16'(9 + 4 * 2 - 4));
		chk(sp, 16'h0052);
		chk(dp, 16'h0062);
		check_copy(16'h0050, 16'h0060, 2);
		$display("test end refused start");
	endtask : run_refused
	task automatic conclude();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge ref_clk);
		run(1'b0, 16'h0300, 16'h0010, 16'h0020, 0);
		run(1'b1, 16'h0000, 16'h0030, 16'h0040, 0);
		run(1'b0, 16'h0103, 16'h0080, 16'h0140, 3);
		run(1'b1, 16'h0102, 16'h0200, 16'h03f0, 258);
		run_refused();
		conclude();
	end
endmodule : tb
